// File: pdc_pkg.sv
// Package for the PWM duty-cycle compare stage: register map, fields, modes
package pdc_pkg;

  localparam int PDC_CH_NUM    = 3;
  localparam int PDC_DUTY_W    = 14;
  localparam int PDC_CNT_W     = 12;
  localparam int PDC_AW        = 4;

  // Word offsets (byte address = 4 * index)
  localparam logic [PDC_AW-1:0] PDC_IDX_DUTY0_LO = 4'h0;
  localparam logic [PDC_AW-1:0] PDC_IDX_DUTY0_HI = 4'h1;
  localparam logic [PDC_AW-1:0] PDC_IDX_DUTY1_LO = 4'h2;
  localparam logic [PDC_AW-1:0] PDC_IDX_DUTY1_HI = 4'h3;
  localparam logic [PDC_AW-1:0] PDC_IDX_DUTY2_LO = 4'h4;
  localparam logic [PDC_AW-1:0] PDC_IDX_DUTY2_HI = 4'h5;
  localparam logic [PDC_AW-1:0] PDC_IDX_PER_LO   = 4'h6;
  localparam logic [PDC_AW-1:0] PDC_IDX_PER_HI   = 4'h7;
  localparam logic [PDC_AW-1:0] PDC_IDX_CTRL     = 4'h8;
  localparam logic [PDC_AW-1:0] PDC_IDX_STATUS   = 4'h9;

  // Control register fields
  localparam int PDC_CTRL_EN_BIT   = 0;
  localparam int PDC_CTRL_MODE_LSB = 1;
  localparam int PDC_CTRL_PS_LSB   = 3;
  // Status register fields
  localparam int PDC_ST_DIR_BIT    = 0;
  localparam int PDC_ST_OUT_LSB    = 1;
  localparam int PDC_ST_CNT_LSB    = 4;

  localparam int PDC_HI_DUTY_W     = 6;
  localparam int PDC_HI_PER_W      = 4;

  localparam logic [1:0] PDC_PS_1TO1 = 2'h0;
  localparam logic [PDC_CNT_W-1:0]  PDC_CNT_ZERO  = 12'h000;
  localparam logic [PDC_DUTY_W-1:0] PDC_DUTY_RST  = 14'h0000;
  localparam logic [PDC_CNT_W-1:0]  PDC_PER_RST   = 12'h000;
  localparam logic [31:0]           PDC_RD_UNMAP  = 32'h0000_0000;

  typedef enum logic [1:0] {
    PDC_MODE_FREE,
    PDC_MODE_SHOT,
    PDC_MODE_UPDN,
    PDC_MODE_UPDN_DBL
  } pdc_mode_type;

  typedef enum logic [1:0] {
    PDC_PH_ONE,
    PDC_PH_TWO,
    PDC_PH_THREE,
    PDC_PH_FOUR
  } pdc_phase_type;

  // Prescale divide counts: 1:1, 1:4, 1:16, 1:64 instruction cycles
  localparam logic [5:0] PDC_PS_DIV4  = 6'h03;
  localparam logic [5:0] PDC_PS_DIV16 = 6'h0f;
  localparam logic [5:0] PDC_PS_DIV64 = 6'h3f;

endpackage

// File: pdc_duty_compare.sv
// Duty-cycle compare stage with local time base and Avalon-MM registers
//
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps

module pdc_duty_compare
  import pdc_pkg::*;
(
  // Clock and reset
  input  wire logic                         clk_sys_i,
  input  wire logic                         reset_n_i,
  // Avalon-MM slave
  input  wire logic [pdc_pkg::PDC_AW-1:0]   avs_address_i,
  input  wire logic                         avs_read_i,
  input  wire logic                         avs_write_i,
  input  wire logic [31:0]                  avs_writedata_i,
  input  wire logic [3:0]                   avs_byteenable_i,
  output logic      [31:0]                  avs_readdata_o,
  output logic                              avs_waitrequest_o,
  // Compare outputs to the override / dead-time stage
  output logic      [pdc_pkg::PDC_CH_NUM-1:0] pwm_cmp_o,
  output logic                              count_down_flag_o,
  output logic      [pdc_pkg::PDC_CNT_W-1:0]  timebase_count_o
);
  import pdc_pkg::*;

  typedef struct packed {
    logic [PDC_CH_NUM-1:0][PDC_DUTY_W-1:0] duty_buf;
    logic [PDC_CH_NUM-1:0][PDC_DUTY_W-1:0] duty_act;
    logic [PDC_CNT_W-1:0]                  per;
    logic                                  en;
    logic [1:0]                            mode;
    logic [1:0]                            ps;
    logic [PDC_CNT_W-1:0]                  cnt;
    logic                                  dir;
    logic [1:0]                            phase;
    logic [5:0]                            ps_cnt;
    logic                                  started;
    logic [PDC_CH_NUM-1:0]                 out;
    logic                                  ack;
    logic                                  waitreq;
    logic [31:0]                           rdata;
  } pdc_state_type;

  pdc_state_type st_r;
  pdc_state_type st_nxt;

  function automatic logic [5:0] ps_limit(input logic [1:0] ps);
    case (ps)
      2'h1:    ps_limit = PDC_PS_DIV4;
      2'h2:    ps_limit = PDC_PS_DIV16;
      2'h3:    ps_limit = PDC_PS_DIV64;
      default: ps_limit = 6'h00;
    endcase
  endfunction

  // Match on upper bits; phase chosen by low bits only at 1:1
  function automatic logic duty_hit(input logic [PDC_DUTY_W-1:0] duty,
                                    input logic [PDC_CNT_W-1:0]  cnt,
                                    input logic [1:0]            phase,
                                    input logic                  tick_ph1,
                                    input logic [1:0]            ps);
    logic up_eq;
    up_eq = (duty[PDC_DUTY_W-1:2] == cnt);
    if (ps == PDC_PS_1TO1)
      duty_hit = up_eq && (phase == duty[1:0]);
    else
      duty_hit = up_eq && tick_ph1;
  endfunction

  // Channel of a duty byte index, two indices per channel
  function automatic logic [1:0] duty_ch(input logic [PDC_AW-1:0] addr);
    logic [PDC_AW-1:0] half;
    half    = addr >> 1;
    duty_ch = half[1:0];
  endfunction

  // Edge-aligned level: forced levels win over match and period start
  function automatic logic edge_out(input logic [PDC_DUTY_W-1:0] duty,
                                    input logic [PDC_CNT_W-1:0]  per,
                                    input logic                  hit,
                                    input logic                  start,
                                    input logic                  cur);
    if (duty == PDC_DUTY_RST) begin
      edge_out = 1'b0;
    end else if (duty[PDC_DUTY_W-1:2] > per) begin
      edge_out = 1'b1;
    end else if (hit) begin
      edge_out = 1'b0;
    end else if (start) begin
      edge_out = 1'b1;
    end else begin
      edge_out = cur;
    end
  endfunction

  // Center-aligned level: set on a match going down, cleared going up
  function automatic logic center_out(input logic [PDC_DUTY_W-1:0] duty,
                                      input logic [PDC_CNT_W-1:0]  per,
                                      input logic                  hit,
                                      input logic                  down,
                                      input logic                  cur);
    if (duty == PDC_DUTY_RST) begin
      center_out = 1'b0;
    end else if (duty[PDC_DUTY_W-1:2] >= per) begin
      center_out = 1'b1;
    end else if (hit) begin
      center_out = down;
    end else begin
      center_out = cur;
    end
  endfunction

  // Byte view of a duty value as software reads it
  function automatic logic [31:0] duty_rd(input logic [PDC_DUTY_W-1:0] duty,
                                          input logic                  hi);
    logic [31:0] v;
    v = PDC_RD_UNMAP;
    if (hi) begin
      v[PDC_HI_DUTY_W-1:0] = duty[PDC_DUTY_W-1:8];
    end else begin
      v[7:0] = duty[7:0];
    end
    duty_rd = v;
  endfunction

  // Byte view of the period as software reads it
  function automatic logic [31:0] per_rd(input logic [PDC_CNT_W-1:0] per,
                                         input logic                 hi);
    logic [31:0] v;
    v = PDC_RD_UNMAP;
    if (hi) begin
      v[PDC_HI_PER_W-1:0] = per[PDC_CNT_W-1:8];
    end else begin
      v[7:0] = per[7:0];
    end
    per_rd = v;
  endfunction

  // Status word: count, output levels, direction
  function automatic logic [31:0] status_word(input logic                  dir,
                                              input logic [PDC_CH_NUM-1:0] out,
                                              input logic [PDC_CNT_W-1:0]  cnt);
    logic [31:0] v;
    v                               = PDC_RD_UNMAP;
    v[PDC_ST_DIR_BIT]               = dir;
    v[PDC_ST_OUT_LSB +: PDC_CH_NUM] = out;
    v[PDC_ST_CNT_LSB +: PDC_CNT_W]  = cnt;
    status_word = v;
  endfunction

  logic                   bus_req;
  logic                   rd_req;
  logic                   wr_en;
  logic                   last_ph;
  logic                   step;
  logic                   ph1_tick;
  logic                   edge_mode;
  logic                   at_per;
  logic                   at_zero;
  logic                   load_act;
  logic                   ch_hit;
  logic [PDC_CNT_W-1:0]   cnt_next;
  logic                   dir_next;
  logic [31:0]            rd_val;
  logic [1:0]             bus_ch;

  always_comb begin
    st_nxt    = st_r;
    // A request counts once; its answer cycle is not a new request
    bus_req   = (avs_read_i || avs_write_i) && !st_r.ack;
    rd_req    = avs_read_i && !st_r.ack;
    // Write lands on the edge that shows waitrequest low
    wr_en     = avs_write_i && st_r.ack && avs_byteenable_i[0];
    last_ph   = (st_r.phase == PDC_PH_FOUR);
    // Time base advances at the end of an instruction cycle once prescaled
    step      = st_r.en && last_ph && (st_r.ps_cnt == ps_limit(st_r.ps));
    ph1_tick  = st_r.phase == PDC_PH_ONE;
    edge_mode = (st_r.mode == PDC_MODE_FREE) || (st_r.mode == PDC_MODE_SHOT);
    at_per    = (st_r.cnt == st_r.per);
    at_zero   = (st_r.cnt == PDC_CNT_ZERO);
    cnt_next  = st_r.cnt;
    dir_next  = st_r.dir;
    load_act  = 1'b0;
    ch_hit    = 1'b0;
    rd_val    = PDC_RD_UNMAP;
    bus_ch    = duty_ch(avs_address_i);

    st_nxt.phase   = st_r.phase + 2'h1;
    st_nxt.ack     = bus_req;
    // Own flop so waitrequest leaves the block with no gate after it
    st_nxt.waitreq = !bus_req;

    if (st_r.en && last_ph) begin
      if (step) begin
        st_nxt.ps_cnt = 6'h00;
      end else begin
        st_nxt.ps_cnt = st_r.ps_cnt + 6'h01;
      end
    end

    // Time base step and active-copy loads
    if (!st_r.en) begin
      load_act = 1'b1;
    end else if (step) begin
      if (edge_mode) begin
        if (at_per) begin
          cnt_next = PDC_CNT_ZERO;
          load_act = 1'b1;
          if (st_r.mode == PDC_MODE_SHOT) begin
            st_nxt.en = 1'b0;
          end
        end else begin
          cnt_next = st_r.cnt + 12'h001;
        end
        dir_next = 1'b0;
      end else begin
        if (st_r.dir) begin
          if (at_zero || st_r.cnt == 12'h001) begin
            dir_next = 1'b0;
            if (at_zero) begin
              cnt_next = 12'h001;
            end else begin
              cnt_next = PDC_CNT_ZERO;
            end
          end else begin
            cnt_next = st_r.cnt - 12'h001;
          end
        end else if (at_per) begin
          dir_next = 1'b1;
          cnt_next = st_r.cnt - 12'h001;
        end else begin
          cnt_next = st_r.cnt + 12'h001;
        end
        // Start already holds fresh values, so a zero at the first step after start is skipped
        if (at_zero && st_r.started) begin
          load_act = 1'b1;
        end
        if (at_per && !st_r.dir && st_r.mode == PDC_MODE_UPDN_DBL) begin
          load_act = 1'b1;
        end
      end
    end
    st_nxt.cnt = cnt_next;
    st_nxt.dir = dir_next;
    if (step) begin
      st_nxt.started = 1'b1;
    end

    // Compare outputs for every channel on the same count and phase
    for (int c = 0; c < PDC_CH_NUM; c++) begin
      ch_hit = duty_hit(st_r.duty_act[c], st_r.cnt, st_r.phase, ph1_tick, st_r.ps);
      if (!st_r.en) begin
        st_nxt.out[c] = 1'b0;
      end else if (edge_mode) begin
        st_nxt.out[c] = edge_out(st_r.duty_act[c], st_r.per, ch_hit,
                                 at_zero && ph1_tick, st_r.out[c]);
      end else begin
        st_nxt.out[c] = center_out(st_r.duty_act[c], st_r.per, ch_hit,
                                   st_r.dir, st_r.out[c]);
      end
    end

    // Active copy only changes at update points
    if (load_act) begin
      st_nxt.duty_act = st_r.duty_buf;
    end

    // Register writes
    if (wr_en) begin
      case (avs_address_i)
        PDC_IDX_DUTY0_LO, PDC_IDX_DUTY1_LO, PDC_IDX_DUTY2_LO: begin
          st_nxt.duty_buf[bus_ch][7:0] = avs_writedata_i[7:0];
        end
        PDC_IDX_DUTY0_HI, PDC_IDX_DUTY1_HI, PDC_IDX_DUTY2_HI: begin
          st_nxt.duty_buf[bus_ch][PDC_DUTY_W-1:8] =
            avs_writedata_i[PDC_HI_DUTY_W-1:0];
        end
        PDC_IDX_PER_LO: begin
          st_nxt.per[7:0] = avs_writedata_i[7:0];
        end
        PDC_IDX_PER_HI: begin
          st_nxt.per[PDC_CNT_W-1:8] = avs_writedata_i[PDC_HI_PER_W-1:0];
        end
        PDC_IDX_CTRL: begin
          st_nxt.en     = avs_writedata_i[PDC_CTRL_EN_BIT];
          st_nxt.mode   = avs_writedata_i[PDC_CTRL_MODE_LSB +: 2];
          st_nxt.ps     = avs_writedata_i[PDC_CTRL_PS_LSB +: 2];
          st_nxt.ps_cnt = 6'h00;
          // Only a rising enable restarts the time base
          if (avs_writedata_i[PDC_CTRL_EN_BIT] && !st_r.en) begin
            st_nxt.started = 1'b0;
            st_nxt.phase   = PDC_PH_ONE;
            if (avs_writedata_i[PDC_CTRL_MODE_LSB + 1]) begin
              st_nxt.cnt = st_r.per;
              st_nxt.dir = 1'b1;
            end else begin
              st_nxt.cnt = PDC_CNT_ZERO;
              st_nxt.dir = 1'b0;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads
    case (avs_address_i)
      PDC_IDX_DUTY0_LO, PDC_IDX_DUTY1_LO, PDC_IDX_DUTY2_LO: begin
        rd_val = duty_rd(st_r.duty_buf[bus_ch], 1'b0);
      end
      PDC_IDX_DUTY0_HI, PDC_IDX_DUTY1_HI, PDC_IDX_DUTY2_HI: begin
        rd_val = duty_rd(st_r.duty_buf[bus_ch], 1'b1);
      end
      PDC_IDX_PER_LO: begin
        rd_val = per_rd(st_r.per, 1'b0);
      end
      PDC_IDX_PER_HI: begin
        rd_val = per_rd(st_r.per, 1'b1);
      end
      PDC_IDX_CTRL: begin
        rd_val = {27'h0000000, st_r.ps, st_r.mode, st_r.en};
      end
      PDC_IDX_STATUS: begin
        rd_val = status_word(st_r.dir, st_r.out, st_r.cnt);
      end
      default: begin
        rd_val = PDC_RD_UNMAP;
      end
    endcase
    // Read data stands until the next read
    if (rd_req) begin
      st_nxt.rdata = rd_val;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r          <= '0;
      st_r.duty_buf <= {PDC_CH_NUM{PDC_DUTY_RST}};
      st_r.duty_act <= {PDC_CH_NUM{PDC_DUTY_RST}};
      st_r.per      <= PDC_PER_RST;
      // Idle bus shows waitrequest high from reset
      st_r.waitreq  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // All outputs straight from the state flops
  assign avs_waitrequest_o = st_r.waitreq;
  assign avs_readdata_o    = st_r.rdata;
  assign pwm_cmp_o         = st_r.out;
  assign count_down_flag_o = st_r.dir;
  assign timebase_count_o  = st_r.cnt;

endmodule

// File: pdc_checker.sv
// Port assertions for the duty compare stage
`timescale 1ns/1ps
module pdc_checker
  import pdc_pkg::*;
(
  // Clock and reset
  input wire logic                             clk_sys_i,
  input wire logic                             reset_n_i,
  // Register bus
  input wire logic [pdc_pkg::PDC_AW-1:0]       avs_address_i,
  input wire logic                             avs_read_i,
  input wire logic                             avs_write_i,
  input wire logic [31:0]                      avs_readdata_o,
  input wire logic                             avs_waitrequest_o,
  // Compare side
  input wire logic [pdc_pkg::PDC_CH_NUM-1:0]   pwm_cmp_o,
  input wire logic                             count_down_flag_o,
  input wire logic [pdc_pkg::PDC_CNT_W-1:0]    timebase_count_o
);
  wire logic req;
  assign req = avs_read_i | avs_write_i;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);
  property p_wait_ack;
    $rose(req) |-> ##1 !avs_waitrequest_o;
  endproperty
  a_wait_ack: assert property (p_wait_ack) else $error("late bus answer");
  property p_wait_one;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer too long");
  property p_wait_idle;
    !req |-> avs_waitrequest_o;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("answer without request");
  property p_unmap;
    avs_read_i && !avs_waitrequest_o && avs_address_i > PDC_IDX_STATUS
      |-> avs_readdata_o == PDC_RD_UNMAP;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_dir_down;
    count_down_flag_o && $past(count_down_flag_o) && !$past(avs_write_i)
      && $changed(timebase_count_o) |-> timebase_count_o == $past(timebase_count_o) - 12'h1;
  endproperty
  a_dir_down: assert property (p_dir_down) else $error("flag set but not down");
  property p_dir_up;
    !count_down_flag_o && !$past(count_down_flag_o) && !$past(avs_write_i)
      && $changed(timebase_count_o) |-> timebase_count_o == PDC_CNT_ZERO
      || timebase_count_o == $past(timebase_count_o) + 12'h1;
  endproperty
  a_dir_up: assert property (p_dir_up) else $error("flag clear but not up");
  property p_cnt_hold;
    $changed(timebase_count_o) && !$past(avs_write_i) |=> $stable(timebase_count_o) [*3];
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("count step too soon");
  property p_rise;
    $rose(pwm_cmp_o[0]) |-> count_down_flag_o || timebase_count_o == PDC_CNT_ZERO;
  endproperty
  a_rise: assert property (p_rise) else $error("output rose off its cause");
  c_rise: cover property ($rose(pwm_cmp_o[2]));
  c_turn: cover property ($fell(count_down_flag_o));
  c_unmap: cover property (avs_read_i && !avs_waitrequest_o && avs_address_i > PDC_IDX_STATUS);
endmodule

bind pdc_duty_compare pdc_checker chk_u (.clk_sys_i, .reset_n_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .pwm_cmp_o, .count_down_flag_o,
  .timebase_count_o);

// File: pdc_gate_model.sv
// Gate driver model: totals active clocks of each compare output
`timescale 1ns/1ps
module pdc_gate_model
  import pdc_pkg::*;
(
  // Clock and window clear
  input  wire logic                            clk_sys_i,
  input  wire logic                            clear_i,
  // Gate inputs
  input  wire logic [pdc_pkg::PDC_CH_NUM-1:0]  gate_i,
  // Active clock totals
  output int                                   hi_cnt_o [pdc_pkg::PDC_CH_NUM]
);
  // Unknown gate level counts as off, like a driver that never turns on
  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < PDC_CH_NUM; i++) begin
      hi_cnt_o[i] <= clear_i ? 0 : hi_cnt_o[i] + int'(gate_i[i] === 1'b1);
    end
  end
endmodule

// File: pdc_duty_compare_tb.sv
// Self-checking bench for the duty compare stage
`timescale 1ns/1ps
module pdc_duty_compare_tb;
  import pdc_pkg::*;
  logic                    clk_sys_i, reset_n_i, avs_read_i, avs_write_i, clr;
  logic                    avs_waitrequest_o, count_down_flag_o;
  logic [PDC_AW-1:0]       avs_address_i;
  logic [3:0]              avs_byteenable_i;
  logic [31:0]             avs_writedata_i, avs_readdata_o, rd, d, m;
  logic [PDC_CH_NUM-1:0]   pwm_cmp_o;
  logic [PDC_CNT_W-1:0]    timebase_count_o, per;
  logic [PDC_DUTY_W-1:0]   duty [PDC_CH_NUM];
  int                      hi [PDC_CH_NUM];
  int                      err_total, check_count, s, p;
  pdc_duty_compare dut_u (.clk_sys_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .pwm_cmp_o,
    .count_down_flag_o, .timebase_count_o);
  pdc_gate_model gate_u (.clk_sys_i, .clear_i(clr), .gate_i(pwm_cmp_o), .hi_cnt_o(hi));
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  // Called just after an edge; holds the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [PDC_AW-1:0] a, input logic [31:0] wd);
    int n;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_address_i <= a;
    avs_writedata_i <= wd;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
      if (n > 20) begin
        err_total++;
        $display("ERROR %0t bus timeout", $time);
        summarize();
      end
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic run(input logic [1:0] mode, input logic [1:0] ps);
    bus(1'b1, PDC_IDX_CTRL, 32'h0);
    bus(1'b1, PDC_IDX_PER_LO, 32'(per[7:0]));
    bus(1'b1, PDC_IDX_PER_HI, 32'(per[11:8]));
    for (int c = 0; c < PDC_CH_NUM; c++) begin
      bus(1'b1, PDC_AW'(2 * c), 32'(duty[c][7:0]));
      bus(1'b1, PDC_AW'(2 * c + 1), 32'(duty[c][13:8]));
    end
    bus(1'b1, PDC_IDX_CTRL, {27'h0, ps, mode, 1'b1});
  endtask
  // Model totals n samples taken after the clearing edge
  task automatic measure(input int n);
    clr <= 1'b1;
    @(posedge clk_sys_i);
    clr <= 1'b0;
    repeat (n + 1) @(posedge clk_sys_i);
  endtask
  task automatic check3(input int e0, input int e1, input int e2);
    chk(hi[0], e0);
    chk(hi[1], e1);
    chk(hi[2], e2);
  endtask
  function automatic int edge_hi(logic [13:0] dv, int st);
    return st == 4 ? int'(dv[13:2]) * 4 + int'(dv[1:0]) : int'(dv[13:2]) * st;
  endfunction
  function automatic logic [13:0] mid_duty(logic [11:0] pv);
    return {12'($urandom_range(pv - 1, 1)), 2'($urandom)};
  endfunction
  initial begin
    void'($urandom(32'hf901));
    reset_n_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = '0;
    avs_writedata_i = '0;
    avs_byteenable_i = 4'hf;
    clr = 1'b0;
    err_total = 0;
    check_count = 0;
    repeat (10) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      d = $urandom;
      m = a[0] ? 32'h3f : 32'hff;
      bus(1'b0, PDC_AW'(a), '0);
      chk(rd, 32'h0);
      bus(1'b1, PDC_AW'(a), d);
      bus(1'b0, PDC_AW'(a), '0);
      chk(rd & m, d & m);
    end
    avs_byteenable_i <= 4'he;
    bus(1'b1, PDC_IDX_DUTY2_HI, ~d);
    avs_byteenable_i <= 4'hf;
    bus(1'b0, PDC_IDX_DUTY2_HI, '0);
    chk(rd & m, d & m);
    bus(1'b1, 4'hc, d);
    bus(1'b0, 4'hc, '0);
    chk(rd, PDC_RD_UNMAP);
    for (int ps = 0; ps < 4; ps++) begin
      s = 4 << (2 * ps);
      per = 12'($urandom_range(12, 6));
      p = (int'(per) + 1) * s;
      duty[0] = mid_duty(per);
      duty[1] = 14'h0;
      duty[2] = {per + 12'h1, 2'($urandom)};
      run(2'h0, 2'(ps));
      repeat (2 * p) @(posedge clk_sys_i);
      measure(p);
      check3(edge_hi(duty[0], s), 0, p);
      duty[0] = mid_duty(per);
      bus(1'b1, PDC_IDX_DUTY0_LO, 32'(duty[0][7:0]));
      bus(1'b1, PDC_IDX_DUTY0_HI, 32'(duty[0][13:8]));
      repeat (2 * p) @(posedge clk_sys_i);
      measure(p);
      check3(edge_hi(duty[0], s), 0, p);
    end
    for (int md = 2; md < 4; md++) begin
      per = 12'($urandom_range(12, 6));
      duty[0] = mid_duty(per);
      duty[2] = {per, 2'h0};
      run(2'(md), 2'h0);
      chk(32'(count_down_flag_o), 32'h1);
      chk(32'(timebase_count_o), 32'(per));
      repeat (24 * per) @(posedge clk_sys_i);
      measure(8 * per);
      check3(8 * int'(duty[0][13:2]), 0, 8 * per);
    end
    per = 12'($urandom_range(12, 6));
    duty[0] = mid_duty(per);
    duty[2] = 14'h0;
    bus(1'b1, PDC_IDX_CTRL, 32'h0);
    clr <= 1'b1;
    @(posedge clk_sys_i);
    clr <= 1'b0;
    run(2'h1, 2'h0);
    repeat (12 * (per + 1)) @(posedge clk_sys_i);
    check3(edge_hi(duty[0], 4), 0, 0);
    bus(1'b0, PDC_IDX_CTRL, '0);
    chk(32'(rd[0]), 32'h0);
    summarize();
  end
endmodule
